/* File: common/pcs_pkg.sv */
// Constants, field layout and operation codes for the peripheral controller sequencer
// Summary of operation
// - Every instruction finishes in one clock, with its flow, datapath and output parts in parallel.
// - The flow part of an instruction picks the instruction fetched in the next cycle.
// - An instruction with no flow operation moves on to the next sequential instruction.
// - An instruction with no datapath operation leaves all datapath state unchanged.
// - An instruction with no output operation keeps the last output value on the control lines.
// - In 22-bit counter mode the six host address lines show the low six counter bits.
// - A bus turns between input and output on the falling clock edge.
// - The source driven onto an output bus is switched on the falling clock edge.
// - New data and counter values are stored on the rising clock edge.
// - The call-if-false operation branches to a label or the FIFO word and pushes the return only on a false condition.
// - Reset drives all control outputs low on the next clock edge.
// - Reset clears the program counter so execution starts at location zero.
package pcs_pkg;

	// ---------------------------------------------------------------
	// Widths
	// ---------------------------------------------------------------
	localparam int PC_W        = 10;
	localparam int INSTR_W     = 49;
	localparam int DATA_W      = 16;
	localparam int REG_CNT     = 16;
	localparam int REG_IDX_W   = 4;
	localparam int STACK_DEPTH = 4;
	localparam int SP_W        = 2;
	localparam int AC_W        = 22;
	localparam int HAD_W       = 6;
	localparam int COND_W      = 8;
	localparam int OP_W        = 4;
	localparam int CSEL_W      = 4;

	// ---------------------------------------------------------------
	// Instruction field positions (lsb of each field)
	// ---------------------------------------------------------------
	localparam int FLOW_LSB    = 45;
	localparam int CSEL_LSB    = 41;
	localparam int TARGET_LSB  = 31;
	localparam int ALU_LSB     = 27;
	localparam int DST_LSB     = 23;
	localparam int SRC_LSB     = 19;
	localparam int BUSDRV_BIT  = 18;
	localparam int BUSSEL_BIT  = 17;
	localparam int OUTEN_BIT   = 16;
	localparam int OUTVAL_LSB  = 0;

	// ---------------------------------------------------------------
	// Condition selection
	// ---------------------------------------------------------------
	localparam logic [CSEL_W-1:0] CSEL_ZERO   = 4'h8;
	localparam logic [CSEL_W-1:0] CSEL_CARRY  = 4'h9;
	localparam logic [CSEL_W-1:0] CSEL_ALWAYS = 4'hF;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [PC_W-1:0]   PC_RESET   = 10'h000;
	localparam logic [DATA_W-1:0] OC_RESET   = 16'h0000;
	localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
	localparam logic [AC_W-1:0]   AC_RESET   = 22'h00_0000;
	localparam logic [SP_W-1:0]   SP_RESET   = 2'h0;

	// ---------------------------------------------------------------
	// Operation codes
	// ---------------------------------------------------------------
	typedef enum logic [OP_W-1:0] {
		FL_PROCEED_SEQUENTIAL,
		FL_JUMP,
		FL_JUMP_IF_TRUE,
		FL_JUMP_IF_FALSE,
		FL_JUMP_FIFO,
		FL_CALL,
		FL_CALL_IF_TRUE,
		FL_CALL_IF_FALSE,
		FL_CALL_IF_FALSE_FIFO,
		FL_RETURN,
		FL_RETURN_IF_TRUE,
		FL_RESTART,
		FL_COUNTER_16,
		FL_COUNTER_22
	} pcs_flow_e;

	typedef enum logic [OP_W-1:0] {
		ALU_NOP,
		ALU_MOVE,
		ALU_ADD,
		ALU_SUB,
		ALU_AND,
		ALU_OR,
		ALU_XOR,
		ALU_INC,
		ALU_DEC,
		ALU_SHL,
		ALU_SHR,
		ALU_LOAD_IN,
		ALU_COUNTER_LOAD,
		ALU_COUNTER_INC,
		ALU_ADDR_LOAD
	} pcs_alu_e;

endpackage : pcs_pkg

/* File: logic/pcs_alu.sv */
// Datapath: register file, arithmetic unit and flags
`timescale 1ns/1ps
`default_nettype none

module pcs_alu (
	input  wire logic                             sys_clk,
	input  wire logic                             rst_b,
	input  wire logic                             clkEn,
	input  wire logic [pcs_pkg::OP_W-1:0]         aluOp,
	input  wire logic [pcs_pkg::REG_IDX_W-1:0]    regDst,
	input  wire logic [pcs_pkg::REG_IDX_W-1:0]    regSrc,
	input  wire logic [pcs_pkg::DATA_W-1:0]       dataIn,
	output logic      [pcs_pkg::DATA_W-1:0]       srcData,
	output logic                                  zeroFlag,
	output logic                                  carryFlag
);

	logic [pcs_pkg::REG_CNT-1:0][pcs_pkg::DATA_W-1:0] regQ, regD;
	logic                                             zeroQ, zeroD;
	logic                                             carryQ, carryD;
	logic [pcs_pkg::DATA_W:0]                         sum;
	logic [pcs_pkg::DATA_W-1:0]                       dstData;
	logic [pcs_pkg::DATA_W-1:0]                       result;
	logic                                             writeReg;
	pcs_pkg::pcs_alu_e                                op;

	assign op        = pcs_pkg::pcs_alu_e'(aluOp);
	assign srcData   = regQ[regSrc];
	assign dstData   = regQ[regDst];
	assign zeroFlag  = zeroQ;
	assign carryFlag = carryQ;

	always_comb begin
		sum      = {1'b0, dstData} + {1'b0, srcData};
		result   = dstData;
		writeReg = 1'b1;
		unique case (op)
			pcs_pkg::ALU_MOVE:    result = srcData;
			pcs_pkg::ALU_ADD:     result = sum[pcs_pkg::DATA_W-1:0];
			pcs_pkg::ALU_SUB: begin
				sum    = {1'b0, dstData} - {1'b0, srcData};
				result = sum[pcs_pkg::DATA_W-1:0];
			end
			pcs_pkg::ALU_AND:     result = dstData & srcData;
			pcs_pkg::ALU_OR:      result = dstData | srcData;
			pcs_pkg::ALU_XOR:     result = dstData ^ srcData;
			pcs_pkg::ALU_INC: begin
				sum    = {1'b0, srcData} + 17'h0_0001;
				result = sum[pcs_pkg::DATA_W-1:0];
			end
			pcs_pkg::ALU_DEC: begin
				sum    = {1'b0, srcData} - 17'h0_0001;
				result = sum[pcs_pkg::DATA_W-1:0];
			end
			pcs_pkg::ALU_SHL: begin
				sum    = {srcData, 1'b0};
				result = sum[pcs_pkg::DATA_W-1:0];
			end
			pcs_pkg::ALU_SHR: begin
				sum    = {srcData[0], 1'b0, srcData[pcs_pkg::DATA_W-1:1]};
				result = sum[pcs_pkg::DATA_W-1:0];
			end
			pcs_pkg::ALU_LOAD_IN: result = dataIn;
			// Nop and the counter ops leave the register file alone
			default:              writeReg = 1'b0;
		endcase
	end

	always_comb begin
		regD   = regQ;
		zeroD  = zeroQ;
		carryD = carryQ;
		if (clkEn && writeReg) begin
			regD[regDst] = result;
			zeroD        = (result == pcs_pkg::DATA_RESET);
			carryD       = sum[pcs_pkg::DATA_W];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			regQ   <= '0;
			zeroQ  <= 1'b0;
			carryQ <= 1'b0;
		end else begin
			regQ   <= regD;
			zeroQ  <= zeroD;
			carryQ <= carryD;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	AST_NOP_HOLDS: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(clkEn && op == pcs_pkg::ALU_NOP) |=> ($stable(regQ) && $stable(zeroQ) && $stable(carryQ)))
		else $error("Nop changed datapath state");

	AST_ADD_RESULT: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(rst_b && clkEn && op == pcs_pkg::ALU_ADD && regDst != regSrc)
		|=> regQ[$past(regDst)] == 16'(($past(dstData) + $past(srcData))))
		else $error("Add result not stored on next rising edge");

endmodule : pcs_alu

`default_nettype wire

/* File: logic/pcs_sequencer.sv */
// Top of the peripheral controller sequencer: fetch, flow, outputs and buses
`timescale 1ns/1ps
`default_nettype none

module pcs_sequencer (
	input  wire logic                              sys_clk,
	input  wire logic                              rst_b,
	input  wire logic                              clkEn,
	output logic      [pcs_pkg::PC_W-1:0]          progAddr,
	input  wire logic [pcs_pkg::INSTR_W-1:0]       progData,
	input  wire logic [pcs_pkg::PC_W-1:0]          fifoTarget,
	input  wire logic [pcs_pkg::COND_W-1:0]        conditionInputs,
	input  wire logic [pcs_pkg::DATA_W-1:0]        dataIn,
	output logic      [pcs_pkg::DATA_W-1:0]        controlOutputLines,
	output logic      [pcs_pkg::HAD_W-1:0]         hostAddressLines,
	output logic                                   hostAddrOeB,
	output logic      [pcs_pkg::DATA_W-1:0]        addrBus,
	output logic                                   addrBusOeB,
	output logic                                   counterWide
);

	// ---------------------------------------------------------------
	// Field decode
	// ---------------------------------------------------------------
	pcs_pkg::pcs_flow_e                       flowOp;
	pcs_pkg::pcs_alu_e                        aluOp;
	logic [pcs_pkg::CSEL_W-1:0]               condSel;
	logic [pcs_pkg::PC_W-1:0]                 target;
	logic [pcs_pkg::REG_IDX_W-1:0]            regDst;
	logic [pcs_pkg::REG_IDX_W-1:0]            regSrc;
	logic                                     busDrive;
	logic                                     busSel;
	logic                                     outEn;
	logic [pcs_pkg::DATA_W-1:0]               outVal;

	// Ten fields decoded side by side from one word
	assign flowOp   = pcs_pkg::pcs_flow_e'(progData[pcs_pkg::FLOW_LSB +: pcs_pkg::OP_W]);
	assign condSel  = progData[pcs_pkg::CSEL_LSB +: pcs_pkg::CSEL_W];
	assign target   = progData[pcs_pkg::TARGET_LSB +: pcs_pkg::PC_W];
	assign aluOp    = pcs_pkg::pcs_alu_e'(progData[pcs_pkg::ALU_LSB +: pcs_pkg::OP_W]);
	assign regDst   = progData[pcs_pkg::DST_LSB +: pcs_pkg::REG_IDX_W];
	assign regSrc   = progData[pcs_pkg::SRC_LSB +: pcs_pkg::REG_IDX_W];
	assign busDrive = progData[pcs_pkg::BUSDRV_BIT];
	assign busSel   = progData[pcs_pkg::BUSSEL_BIT];
	assign outEn    = progData[pcs_pkg::OUTEN_BIT];
	assign outVal   = progData[pcs_pkg::OUTVAL_LSB +: pcs_pkg::DATA_W];

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic [pcs_pkg::COND_W-1:0] condMetaQ, condSyncQ;
	logic [pcs_pkg::DATA_W-1:0] dataMetaQ, dataSyncQ;

	// Free running so a slow enable cannot stretch the settling time
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			condMetaQ <= '0;
			condSyncQ <= '0;
			dataMetaQ <= '0;
			dataSyncQ <= '0;
		end else begin
			condMetaQ <= conditionInputs;
			condSyncQ <= condMetaQ;
			dataMetaQ <= dataIn;
			dataSyncQ <= dataMetaQ;
		end
	end

	// ---------------------------------------------------------------
	// Datapath
	// ---------------------------------------------------------------
	logic [pcs_pkg::DATA_W-1:0] srcData;
	logic                       zeroFlag;
	logic                       carryFlag;

	pcs_alu uAlu (
		.sys_clk   (sys_clk),
		.rst_b     (rst_b),
		.clkEn     (clkEn),
		.aluOp     (aluOp),
		.regDst    (regDst),
		.regSrc    (regSrc),
		.dataIn    (dataSyncQ),
		.srcData   (srcData),
		.zeroFlag  (zeroFlag),
		.carryFlag (carryFlag)
	);

	// ---------------------------------------------------------------
	// Condition and flow
	// ---------------------------------------------------------------
	logic condTrue;

	// Inputs are sampled, not latched, during the testing instruction
	always_comb begin
		if (condSel == pcs_pkg::CSEL_ALWAYS)
			condTrue = 1'b1;
		else if (condSel == pcs_pkg::CSEL_ZERO)
			condTrue = zeroFlag;
		else if (condSel == pcs_pkg::CSEL_CARRY)
			condTrue = carryFlag;
		else if (!condSel[3])
			condTrue = condSyncQ[condSel[2:0]];
		else
			condTrue = 1'b0;
	end

	logic [pcs_pkg::STACK_DEPTH-1:0][pcs_pkg::PC_W-1:0] stackQ, stackD;
	logic [pcs_pkg::SP_W-1:0]                           spQ, spD;
	logic [pcs_pkg::PC_W-1:0]                           pcQ, pcD;
	logic [pcs_pkg::PC_W-1:0]                           pcNext;
	logic                                               wideQ, wideD;
	logic                                               push;
	logic                                               pop;

	assign pcNext = pcQ + 10'h001;

	always_comb begin
		pcD    = pcNext;
		push   = 1'b0;
		pop    = 1'b0;
		wideD  = wideQ;
		unique case (flowOp)
			pcs_pkg::FL_PROCEED_SEQUENTIAL: pcD = pcNext;
			pcs_pkg::FL_JUMP:               pcD = target;
			pcs_pkg::FL_JUMP_IF_TRUE:       pcD = condTrue ? target : pcNext;
			pcs_pkg::FL_JUMP_IF_FALSE:      pcD = condTrue ? pcNext : target;
			pcs_pkg::FL_JUMP_FIFO:          pcD = fifoTarget;
			pcs_pkg::FL_CALL: begin
				pcD  = target;
				push = 1'b1;
			end
			pcs_pkg::FL_CALL_IF_TRUE: begin
				pcD  = condTrue ? target : pcNext;
				push = condTrue;
			end
			pcs_pkg::FL_CALL_IF_FALSE: begin
				pcD  = condTrue ? pcNext : target;
				push = !condTrue;
			end
			pcs_pkg::FL_CALL_IF_FALSE_FIFO: begin
				pcD  = condTrue ? pcNext : fifoTarget;
				push = !condTrue;
			end
			pcs_pkg::FL_RETURN: begin
				pcD = stackQ[spQ - 2'h1];
				pop = 1'b1;
			end
			pcs_pkg::FL_RETURN_IF_TRUE: begin
				pcD = condTrue ? stackQ[spQ - 2'h1] : pcNext;
				pop = condTrue;
			end
			pcs_pkg::FL_RESTART:            pcD = pcs_pkg::PC_RESET;
			pcs_pkg::FL_COUNTER_16:         wideD = 1'b0;
			pcs_pkg::FL_COUNTER_22:         wideD = 1'b1;
			// Unused codes behave as sequential
			default:                        pcD = pcNext;
		endcase
	end

	// The stack wraps on overflow; deep nesting overwrites the oldest entry
	always_comb begin
		stackD = stackQ;
		spD    = spQ;
		if (push) begin
			stackD[spQ] = pcNext;
			spD         = spQ + 2'h1;
		end else if (pop) begin
			spD = spQ - 2'h1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			pcQ    <= pcs_pkg::PC_RESET;
			spQ    <= pcs_pkg::SP_RESET;
			stackQ <= '0;
			wideQ  <= 1'b0;
		end else if (clkEn) begin
			pcQ    <= pcD;
			spQ    <= spD;
			stackQ <= stackD;
			wideQ  <= wideD;
		end
	end

	// ---------------------------------------------------------------
	// Output control register
	// ---------------------------------------------------------------
	logic [pcs_pkg::DATA_W-1:0] ocQ, ocD;

	always_comb begin
		ocD = ocQ;
		if (outEn)
			ocD = outVal;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			ocQ <= pcs_pkg::OC_RESET;
		else if (clkEn)
			ocQ <= ocD;
	end

	// ---------------------------------------------------------------
	// Address counter and address register
	// ---------------------------------------------------------------
	logic [pcs_pkg::AC_W-1:0]   counterQ, counterD;
	logic [pcs_pkg::DATA_W-1:0] addrRegQ, addrRegD;
	logic                       busDriveQ, busDriveD;
	logic                       busSelQ, busSelD;

	always_comb begin
		counterD  = counterQ;
		addrRegD  = addrRegQ;
		busDriveD = busDrive;
		busSelD   = busSel;
		if (aluOp == pcs_pkg::ALU_COUNTER_LOAD)
			counterD = {6'h00, srcData};
		else if (aluOp == pcs_pkg::ALU_COUNTER_INC && wideQ)
			counterD = counterQ + 22'h00_0001;
		else if (aluOp == pcs_pkg::ALU_COUNTER_INC)
			counterD = {counterQ[pcs_pkg::AC_W-1:pcs_pkg::DATA_W], counterQ[15:0] + 16'h0001};
		if (aluOp == pcs_pkg::ALU_ADDR_LOAD)
			addrRegD = srcData;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			counterQ  <= pcs_pkg::AC_RESET;
			addrRegQ  <= pcs_pkg::DATA_RESET;
			busDriveQ <= 1'b0;
			busSelQ   <= 1'b0;
		end else if (clkEn) begin
			counterQ  <= counterD;
			addrRegQ  <= addrRegD;
			busDriveQ <= busDriveD;
			busSelQ   <= busSelD;
		end
	end

	// ---------------------------------------------------------------
	// Falling-edge bus direction and source
	// ---------------------------------------------------------------
	// Decided on the rising edge, applied half a cycle later so the
	// bus never turns while a value is being captured
	logic [pcs_pkg::DATA_W-1:0] addrOutQ, addrOutD;
	logic                       addrOeBQ, addrOeBD;
	logic [pcs_pkg::HAD_W-1:0]  hadQ, hadD;
	logic                       hadOeBQ, hadOeBD;
	logic [pcs_pkg::DATA_W-1:0] counterView;

	assign counterView = wideQ ? counterQ[pcs_pkg::AC_W-1:pcs_pkg::HAD_W]
	                           : counterQ[pcs_pkg::DATA_W-1:0];

	always_comb begin
		addrOeBD = !busDriveQ;
		addrOutD = busSelQ ? addrRegQ : counterView;
		hadOeBD  = !wideQ;
		hadD     = counterQ[pcs_pkg::HAD_W-1:0];
	end

	always_ff @(negedge sys_clk) begin
		if (!rst_b) begin
			addrOeBQ <= 1'b1;
			addrOutQ <= pcs_pkg::DATA_RESET;
			hadOeBQ  <= 1'b1;
			hadQ     <= '0;
		end else if (clkEn) begin
			addrOeBQ <= addrOeBD;
			addrOutQ <= addrOutD;
			hadOeBQ  <= hadOeBD;
			hadQ     <= hadD;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign progAddr           = pcQ;
	assign controlOutputLines = ocQ;
	assign hostAddressLines   = hadQ;
	assign hostAddrOeB        = hadOeBQ;
	assign addrBus            = addrOutQ;
	assign addrBusOeB         = addrOeBQ;
	assign counterWide        = wideQ;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	wire logic armed = rst_b && clkEn; // The release edge itself executes nothing

	sequence seqCallFalseTaken;
		armed && (flowOp == pcs_pkg::FL_CALL_IF_FALSE) && !condTrue;
	endsequence

	sequence seqCallFalseSkipped;
		armed && (flowOp == pcs_pkg::FL_CALL_IF_FALSE) && condTrue;
	endsequence

	AST_CALL_FALSE_TAKEN: assert property (@(posedge sys_clk) disable iff (!rst_b)
		seqCallFalseTaken |=> (pcQ == $past(target)) && (spQ == $past(spQ) + 2'h1)
		&& (stackQ[$past(spQ)] == $past(pcNext)))
		else $error("Call on false did not branch and push");

	AST_CALL_FALSE_SKIP: assert property (@(posedge sys_clk) disable iff (!rst_b)
		seqCallFalseSkipped |=> (pcQ == $past(pcQ) + 10'h001) && $stable(spQ))
		else $error("Call on false acted on a true condition");

	AST_PROCEED: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(armed && flowOp == pcs_pkg::FL_PROCEED_SEQUENTIAL) |=> progAddr == $past(pcQ) + 10'h001)
		else $error("Sequential step missed");

	AST_JUMP_NEXT: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(armed && flowOp == pcs_pkg::FL_JUMP) |=> progAddr == $past(target))
		else $error("Jump target not fetched next cycle");

	AST_PARALLEL: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(armed && flowOp == pcs_pkg::FL_JUMP && outEn)
		|=> (progAddr == $past(target)) && (controlOutputLines == $past(outVal)))
		else $error("Flow and output parts not done in one cycle");

	AST_OUT_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(!outEn || !clkEn) |=> $stable(controlOutputLines))
		else $error("Control outputs changed without an output operation");

	AST_OUT_LOAD: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(armed && outEn) |=> controlOutputLines == $past(outVal))
		else $error("Output operation not applied");

	AST_RESET_STATE: assert property (@(posedge sys_clk)
		!rst_b |=> (controlOutputLines == pcs_pkg::OC_RESET) && (progAddr == pcs_pkg::PC_RESET))
		else $error("Reset did not clear outputs and program counter");

	AST_HOST_ADDR: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(clkEn && $past(clkEn) && !hostAddrOeB)
		|-> hostAddressLines == counterQ[pcs_pkg::HAD_W-1:0])
		else $error("Host address lines do not follow the low counter bits");

	AST_DRIVE_HALF: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(armed && busDrive) ##1 clkEn |-> !addrBusOeB)
		else $error("Address bus not turned on at the falling edge");

endmodule : pcs_sequencer

`default_nettype wire

/* File: verif/pcs_prog_model.sv */
// Program store and condition pins on the far side of the sequencer
`timescale 1ns/1ps
`default_nettype none

module pcs_prog_model #(
	parameter logic [pcs_pkg::PC_W-1:0] FIFO_WORD = 10'h01E
) (
	input  wire logic [pcs_pkg::PC_W-1:0]    progAddr,
	output logic      [pcs_pkg::INSTR_W-1:0] progData,
	output logic      [pcs_pkg::PC_W-1:0]    fifoTarget,
	output logic      [pcs_pkg::COND_W-1:0]  conditionInputs
);
	// ---------------------------------------------------------------
	// Store
	// ---------------------------------------------------------------
	logic [pcs_pkg::INSTR_W-1:0] mem [0:1023];

	// Unloaded words read as unknown, so a stray fetch shows up
	assign progData        = mem[progAddr];
	assign fifoTarget      = FIFO_WORD;
	// Pins never move, so every test sees a settled level
	assign conditionInputs = 8'h01;
endmodule : pcs_prog_model
`default_nettype wire

/* File: verif/tb.sv */
// Self-checking bench for the peripheral controller sequencer
`timescale 1ns/1ps
`default_nettype none

module tb;
	typedef struct {
		logic [9:0]  a;
		logic [48:0] w;
		logic [15:0] oc;
		logic [16:0] bus;
	} pcs_row_s;

	localparam logic [16:0] BUS_IDLE = 17'h1_0000;

	logic        sys_clk = 1'b0;
	logic        rst_b   = 1'b0;
	logic        clkEn   = 1'b1;
	logic [15:0] dataIn  = 16'h003F;
	logic [9:0]  progAddr;
	logic [9:0]  fifoTarget;
	logic [48:0] progData;
	logic [7:0]  conditionInputs;
	logic [15:0] controlOutputLines;
	logic [5:0]  hostAddressLines;
	logic        hostAddrOeB;
	logic [15:0] addrBus;
	logic        addrBusOeB;
	logic        counterWide;
	int          n_errors    = 0;
	int          comparisons = 0;
	pcs_row_s    rows [17];

	always #4 sys_clk = ~sys_clk;

	pcs_sequencer pcs_sequencer_inst (.sys_clk(sys_clk), .rst_b(rst_b), .clkEn(clkEn),
		.progAddr(progAddr), .progData(progData), .fifoTarget(fifoTarget),
		.conditionInputs(conditionInputs), .dataIn(dataIn),
		.controlOutputLines(controlOutputLines), .hostAddressLines(hostAddressLines),
		.hostAddrOeB(hostAddrOeB), .addrBus(addrBus), .addrBusOeB(addrBusOeB),
		.counterWide(counterWide));

	pcs_prog_model pcs_prog_model_inst (.progAddr(progAddr), .progData(progData),
		.fifoTarget(fifoTarget), .conditionInputs(conditionInputs));

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [48:0] mk(input logic [3:0] fl, input logic [3:0] cs,
		input logic [9:0] tg, input logic [3:0] al, input logic [2:0] bo, input logic [15:0] v);
		return {fl, cs, tg, al, 4'h1, 4'h1, bo, v};
	endfunction : mk

	function automatic logic [48:0] rg(input logic [48:0] w, input logic [7:0] ds);
		return {w[48:27], ds, w[18:0]};
	endfunction : rg

	task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] e);
		comparisons++;
		if (s !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic final_report;
		$display("Comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : final_report

	initial begin
		repeat (500) @(posedge sys_clk);
		n_errors++;
		final_report();
	end

	// ---------------------------------------------------------------
	// Sequence
	// ---------------------------------------------------------------
	initial begin
		rows[0]  = '{10'h000, mk(4'd0, 4'h0, 10'h000, 4'd0, 3'b001, 16'h1234), 16'h1234, BUS_IDLE};
		rows[1]  = '{10'h001, mk(4'd0, 4'h0, 10'h000, 4'd0, 3'b000, 16'h0000), 16'h1234, BUS_IDLE};
		rows[2]  = '{10'h002, mk(4'd1, 4'h0, 10'h008, 4'd0, 3'b001, 16'h00FF), 16'h00FF, BUS_IDLE};
		rows[3]  = '{10'h008, mk(4'd7, 4'h0, 10'h014, 4'd0, 3'b000, 16'h0000), 16'h00FF, BUS_IDLE};
		rows[4]  = '{10'h009, mk(4'd7, 4'hE, 10'h014, 4'd0, 3'b000, 16'h0000), 16'h00FF, BUS_IDLE};
		rows[5]  = '{10'h014, mk(4'd9, 4'h0, 10'h000, 4'd0, 3'b001, 16'h8001), 16'h8001, BUS_IDLE};
		rows[6]  = '{10'h00A, mk(4'd8, 4'hE, 10'h000, 4'd0, 3'b000, 16'h0000), 16'h8001, BUS_IDLE};
		rows[7]  = '{10'h01E, mk(4'd9, 4'h0, 10'h000, 4'd0, 3'b000, 16'h0000), 16'h8001, BUS_IDLE};
		rows[8]  = '{10'h00B, mk(4'd0, 4'h0, 10'h000, 4'd11, 3'b000, 16'h0000), 16'h8001, BUS_IDLE};
		rows[9]  = '{10'h00C, mk(4'd13, 4'h0, 10'h000, 4'd12, 3'b000, 16'h0000), 16'h8001,
			BUS_IDLE};
		rows[10] = '{10'h00D, mk(4'd0, 4'h0, 10'h000, 4'd0, 3'b100, 16'h0000), 16'h8001,
			17'h0_0000};
		// Add into r2, load the address register, then drive it out
		rows[11] = '{10'h00E, rg(mk(4'd2, 4'hF, 10'h020, 4'd2, 3'b000, 16'h0000), 8'h21),
			16'h8001, BUS_IDLE};
		rows[12] = '{10'h020, rg(mk(4'd3, 4'h8, 10'h024, 4'd14, 3'b000, 16'h0000), 8'h12),
			16'h8001, BUS_IDLE};
		rows[13] = '{10'h024, mk(4'd6, 4'h0, 10'h030, 4'd0, 3'b110, 16'h0000), 16'h8001,
			17'h0_003F};
		rows[14] = '{10'h030, mk(4'd10, 4'hF, 10'h000, 4'd0, 3'b001, 16'hA5A5), 16'hA5A5,
			BUS_IDLE};
		rows[15] = '{10'h025, mk(4'd12, 4'h0, 10'h000, 4'd13, 3'b100, 16'h0000), 16'hA5A5,
			17'h0_0040};
		rows[16] = '{10'h026, mk(4'd11, 4'h0, 10'h000, 4'd13, 3'b100, 16'h0000), 16'hA5A5,
			17'h0_0041};
		foreach (rows[i]) pcs_prog_model_inst.mem[rows[i].a] = rows[i].w;
		repeat (10) @(posedge sys_clk);
		rst_b <= 1'b1;
		#1;
		chk("progAddr", progAddr, 0);
		chk("controlOutputLines", controlOutputLines, 0);
		chk("addrBusOeB", addrBusOeB, 1);
		chk("hostAddrOeB", hostAddrOeB, 1);
		foreach (rows[i]) begin
			chk("progAddr", progAddr, rows[i].a);
			@(posedge sys_clk);
			#1;
			chk("controlOutputLines", controlOutputLines, rows[i].oc);
			if (i == 10) begin
				chk("addrBusOeB", addrBusOeB, 1);
			end
			@(negedge sys_clk);
			#1;
			chk("addrBus", {addrBusOeB, addrBus}, rows[i].bus);
			if (i == 10) begin
				chk("hostAddressLines", hostAddressLines, 6'h3F);
				chk("hostAddrOeB", hostAddrOeB, 0);
				chk("counterWide", counterWide, 1);
			end
			if (i == 16) begin
				chk("hostAddressLines", hostAddressLines, 6'h01);
				chk("hostAddrOeB", hostAddrOeB, 1);
				chk("counterWide", counterWide, 0);
			end
		end
		chk("progAddr", progAddr, 0);
		// Frozen clock enable: the word at zero runs first, then nothing moves
		@(posedge sys_clk);
		clkEn <= 1'b0;
		repeat (3) @(posedge sys_clk);
		#1;
		chk("progAddr", progAddr, 1);
		chk("controlOutputLines", controlOutputLines, 16'h1234);
		@(posedge sys_clk);
		clkEn <= 1'b1;
		rst_b <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		#1;
		chk("progAddr", progAddr, 0);
		chk("controlOutputLines", controlOutputLines, 0);
		chk("counterWide", counterWide, 0);
		chk("addrBusOeB", addrBusOeB, 1);
		final_report();
	end
endmodule : tb
`default_nettype wire
